// ---- core/fssr_device.sv ----
// Sensor end: frame statistics, self test and resolution registers on a serial port.
// Assumes a pixel stream on CLK_SYS and a host that keeps the link protocol.
`timescale 1ns/1ns
`include "fssr_defines.svh"

// Function
// RL1 - Sum pixels in 18 bits, report top eight
// RL2 - Pixel total capped at 167, per frame
// RL3 - Host averages as total times 1024/676
// RL4 - Report darkest pixel, 0 to 254, per frame
// RL5 - First result byte holds F4 after test
// RL6 - Second result byte holds 54 after test
// RL7 - Third result byte holds 6D after test
// RL8 - Fourth result byte holds EB after test
// RL9 - Writing run bit one starts self test
// RL10 - Test lasts 250 ms, then results ready
// RL11 - Host stays off the port during test
// RL12 - Host resets chip before starting test
// RL13 - Host resets chip after test completes
// RL14 - Resolution select bits pick 400 to 1600
// RL15 - Motion counts scale with selected resolution
// RL16 - Host writes bit seven zero, keeps reserved
// RL17 - Resolution register resets to 800 cpi
module fssr_device
    import fssr_pkg::*;
#(
    parameter int unsigned TEST_CYCLES = 32'(`FSSR_TEST_CYC_DEF)
) (
    input wire logic CLK_SYS,
    input wire logic SRST,
    fssr_link_if.device LINK,
    input wire logic PIX_VALID,
    input wire logic [7:0] PIX_DATA,
    input wire logic FRAME_END,
    input wire logic MOT_VALID,
    input wire logic [7:0] MOT_STEP,
    output logic [11:0] MOT_SCALED,
    output logic [1:0] CPI_SELECT,
    output logic SELFTEST_BUSY
);

    localparam int PIN_NCS = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_MOSI = 2;
    localparam int PIN_RST = 3;

    // Select stages start at the idle high level so no false select follows reset
    localparam fssr_dev_st_t DEV_RST = '{
        syn: 12'h007,
        pin: 4'b0001,
        mode: D_RUN,
        tcnt: '0,
        bits: '0,
        shin: '0,
        cmd: '0,
        tx: '0,
        miso_oe: 1'b0,
        acc: '0,
        minv: `FSSR_PIX_MAX,
        total: `FSSR_RST_PIX_TOTAL,
        darkest: `FSSR_RST_DARKEST,
        res: `FSSR_RST_RES_CFG,
        result: {4{`FSSR_RST_RESULT}},
        scaled: '0
    };

    fssr_dev_st_t st;
    fssr_dev_st_t next_st;
    logic [3:0] pin_raw;

    assign pin_raw = {LINK.chip_rst, LINK.mosi, LINK.sclk, LINK.ncs};

    // Register read decode
    function automatic logic [7:0] fssr_read(input fssr_dev_st_t s, input logic [6:0] a);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            `FSSR_ADDR_PIX_TOTAL: d = s.total;
            `FSSR_ADDR_DARKEST: d = s.darkest;
            `FSSR_ADDR_RESULT0: d = s.result[0];
            `FSSR_ADDR_RESULT1: d = s.result[1];
            `FSSR_ADDR_RESULT2: d = s.result[2];
            `FSSR_ADDR_RESULT3: d = s.result[3];
            `FSSR_ADDR_RES_CFG: d = {1'b0, s.res[6:0]};
            default: d = 8'h00;
        endcase
        return d;
    endfunction : fssr_read

    always_comb begin
        logic rise;
        logic fall;
        logic sel;
        logic mosi_bit;
        logic [7:0] p;
        logic [18:0] sum;
        logic [17:0] a_new;
        logic [7:0] m_new;
        logic [7:0] wdata;
        logic [2:0] mult;
        logic [11:0] step_ext;
        fssr_dev_st_t tmp;
        rise = 1'b0;
        fall = 1'b0;
        sel = 1'b0;
        mosi_bit = 1'b0;
        p = 8'h00;
        sum = '0;
        a_new = '0;
        m_new = 8'h00;
        wdata = 8'h00;
        mult = 3'h0;
        step_ext = 12'h000;
        tmp = DEV_RST;
        next_st = st;

        // Pin synchronisers, change accepted when second and third stages agree
        for (int i = 0; i < 4; i++) begin
            next_st.syn[i] = {st.syn[i][1:0], pin_raw[i]};
            if (st.syn[i][1] == st.syn[i][2]) begin
                next_st.pin[i] = st.syn[i][2];
            end
        end
        rise = next_st.pin[PIN_SCLK] & ~st.pin[PIN_SCLK];
        fall = ~next_st.pin[PIN_SCLK] & st.pin[PIN_SCLK];
        sel = ~next_st.pin[PIN_NCS];
        mosi_bit = st.pin[PIN_MOSI];

        // Frame statistics
        p = (PIX_DATA > `FSSR_PIX_MAX) ? `FSSR_PIX_MAX : PIX_DATA; // [RL4]
        sum = {1'b0, st.acc} + {11'h000, p};
        a_new = st.acc;
        m_new = st.minv;
        if (PIX_VALID) begin
            a_new = sum[18] ? 18'h3ffff : sum[17:0]; // [RL1]
            if (p < m_new) begin
                m_new = p; // [RL4]
            end
        end
        if (FRAME_END) begin
            next_st.total = (a_new[17:10] > `FSSR_TOTAL_MAX) ? `FSSR_TOTAL_MAX
                                                            : a_new[17:10]; // [RL1] [RL2]
            next_st.darkest = m_new; // [RL4]
            next_st.acc = '0;
            next_st.minv = `FSSR_PIX_MAX;
        end else begin
            next_st.acc = a_new;
            next_st.minv = m_new;
        end

        // Motion scaling by resolution step
        mult = {1'b0, st.res[`FSSR_CPI_HI:`FSSR_CPI_LO]} + 3'h1;
        step_ext = {{4{MOT_STEP[7]}}, MOT_STEP};
        if (MOT_VALID) begin
            next_st.scaled = step_ext * {9'h000, mult}; // [RL15]
        end

        // Serial port, ignored while the self test runs
        if (!sel) begin
            next_st.bits = '0;
            next_st.miso_oe = 1'b0;
        end else begin
            next_st.miso_oe = 1'b1;
            if (rise && st.mode == D_RUN && st.bits != 5'd16) begin // [RL11]
                next_st.shin = {st.shin[6:0], mosi_bit};
                next_st.bits = st.bits + 5'd1;
                if (st.bits == 5'd7) begin
                    next_st.cmd = {st.shin[6:0], mosi_bit};
                    next_st.tx = fssr_read(st, {st.shin[5:0], mosi_bit});
                end
                if (st.bits == 5'd15 && st.cmd[`FSSR_CMD_WRITE_POS]) begin
                    wdata = {st.shin[6:0], mosi_bit};
                    case (st.cmd[6:0])
                        `FSSR_ADDR_DIAG: begin
                            if (wdata[`FSSR_DIAG_RUN_POS]) begin
                                next_st.mode = D_TEST; // [RL9]
                                next_st.tcnt = '0;
                            end
                        end
                        `FSSR_ADDR_RES_CFG: begin
                            next_st.res = {1'b0, wdata[6:0]}; // [RL14]
                        end
                        default: begin
                            next_st.res = st.res;
                        end
                    endcase
                end
            end
            if (fall && st.bits >= 5'd9) begin
                next_st.tx = {st.tx[6:0], 1'b0};
            end
        end

        // Self-test timer
        case (st.mode)
            D_TEST: begin
                next_st.tcnt = st.tcnt + 23'd1;
                if (st.tcnt == 23'(TEST_CYCLES - 32'd1)) begin // [RL10]
                    next_st.mode = D_RUN;
                    next_st.result[0] = `FSSR_RESULT0_VAL; // [RL5]
                    next_st.result[1] = `FSSR_RESULT1_VAL; // [RL6]
                    next_st.result[2] = `FSSR_RESULT2_VAL; // [RL7]
                    next_st.result[3] = `FSSR_RESULT3_VAL; // [RL8]
                end
            end
            default: begin
                next_st.tcnt = '0;
            end
        endcase

        // Chip reset from the host returns everything but the pin stages
        if (next_st.pin[PIN_RST]) begin
            tmp = DEV_RST; // [RL17]
            tmp.syn = next_st.syn;
            tmp.pin = next_st.pin;
            next_st = tmp;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            st <= DEV_RST; // [RL17]
        end else begin
            st <= next_st;
        end
    end

    assign LINK.miso = st.tx[7];
    assign LINK.miso_oe = st.miso_oe;
    assign MOT_SCALED = st.scaled;
    assign CPI_SELECT = st.res[`FSSR_CPI_HI:`FSSR_CPI_LO]; // [RL14]
    assign SELFTEST_BUSY = (st.mode == D_TEST);

endmodule : fssr_device

// ---- core/fssr_host.sv ----
// Host end: serial-port master with chip reset and self-test sequencing.
// Assumes one command at a time from the user side, handshaken by valid and ready.
`timescale 1ns/1ns
`include "fssr_defines.svh"

module fssr_host
    import fssr_pkg::*;
#(
    parameter int unsigned TEST_WAIT = 32'(`FSSR_TEST_CYC_DEF) + `FSSR_TEST_MARGIN
) (
    input wire logic CLK_SYS,
    input wire logic SRST,
    fssr_link_if.host LINK,
    input wire logic CMD_VALID,
    input wire logic CMD_WRITE,
    input wire logic [6:0] CMD_ADDR,
    input wire logic [7:0] CMD_WDATA,
    output logic CMD_READY,
    output logic RSP_VALID,
    output logic [7:0] RSP_RDATA,
    output logic SELFTEST_DONE
);

    localparam fssr_host_st_t HOST_RST = '{
        state: H_IDLE,
        tmr: '0,
        hcnt: '0,
        sh: '0,
        rx: '0,
        ncs: 1'b1,
        sclk: 1'b0,
        mosi: 1'b0,
        chip_rst: 1'b0,
        ms: 3'b111,
        miso_f: 1'b1,
        ready: 1'b0,
        rsp_valid: 1'b0,
        rsp_data: '0,
        test_pend: 1'b0,
        need_reset: 1'b0,
        test_done: 1'b0,
        shadow: 5'(`FSSR_RST_RES_CFG),
        wcnt: '0
    };

    fssr_host_st_t st;
    fssr_host_st_t next_st;

    always_comb begin
        logic is_test;
        logic is_result;
        logic [7:0] wdata;
        is_test = CMD_WRITE && CMD_ADDR == `FSSR_ADDR_DIAG && CMD_WDATA[`FSSR_DIAG_RUN_POS];
        is_result = !CMD_WRITE && CMD_ADDR >= `FSSR_ADDR_RESULT0
                    && CMD_ADDR <= `FSSR_ADDR_RESULT3;
        wdata = CMD_WDATA;
        next_st = st;
        next_st.rsp_valid = 1'b0;
        next_st.ms = {st.ms[1:0], LINK.miso_line};
        if (st.ms[1] == st.ms[2]) begin
            next_st.miso_f = st.ms[2];
        end
        if (CMD_ADDR == `FSSR_ADDR_RES_CFG) begin
            wdata = {1'b0, CMD_WDATA[`FSSR_CPI_HI:`FSSR_CPI_LO], st.shadow}; // [RL16]
        end

        case (st.state)
            H_IDLE: begin
                next_st.ready = 1'b1;
                if (CMD_VALID && st.ready) begin
                    next_st.ready = 1'b0;
                    next_st.sh = {CMD_WRITE, CMD_ADDR, CMD_WRITE ? wdata : 8'h00};
                    next_st.test_pend = is_test;
                    next_st.tmr = '0;
                    if (is_test || (st.need_reset && !is_result)) begin // [RL12] [RL13]
                        next_st.state = H_RESET;
                        next_st.test_done = 1'b0;
                    end else begin
                        next_st.state = H_LEAD;
                    end
                end
            end
            H_RESET: begin
                next_st.chip_rst = 1'b1;
                next_st.tmr = st.tmr + 5'd1;
                if (st.tmr == `FSSR_CHIP_RST_CYC) begin
                    next_st.chip_rst = 1'b0;
                    next_st.need_reset = 1'b0;
                    next_st.shadow = 5'(`FSSR_RST_RES_CFG);
                    next_st.tmr = '0;
                    next_st.state = H_LEAD;
                end
            end
            H_LEAD: begin
                next_st.ncs = 1'b0;
                next_st.tmr = st.tmr + 5'd1;
                if (st.tmr == `FSSR_SCLK_HALF - 5'd1) begin
                    next_st.tmr = '0;
                    next_st.hcnt = '0;
                    next_st.mosi = st.sh[15];
                    next_st.state = H_BITS;
                end
            end
            H_BITS: begin
                next_st.tmr = st.tmr + 5'd1;
                if (st.tmr == `FSSR_SCLK_HALF - 5'd1) begin
                    next_st.tmr = '0;
                    next_st.hcnt = st.hcnt + 6'd1;
                    if (!st.hcnt[0]) begin
                        next_st.sclk = 1'b1;
                    end else begin
                        next_st.sclk = 1'b0;
                        next_st.rx = {st.rx[6:0], st.miso_f};
                        next_st.sh = {st.sh[14:0], 1'b0};
                        next_st.mosi = st.sh[14];
                        if (st.hcnt == 6'd31) begin
                            next_st.state = H_TAIL;
                        end
                    end
                end
            end
            H_TAIL: begin
                next_st.tmr = st.tmr + 5'd1;
                if (st.tmr == `FSSR_SCLK_HALF - 5'd1) begin
                    next_st.tmr = '0;
                    next_st.hcnt = st.hcnt + 6'd1;
                    next_st.ncs = 1'b1;
                    if (st.hcnt != 6'd32) begin
                        next_st.rsp_valid = 1'b1;
                        next_st.rsp_data = st.rx;
                        next_st.wcnt = '0;
                        next_st.state = st.test_pend ? H_TEST : H_IDLE;
                    end
                end
            end
            H_TEST: begin
                next_st.wcnt = st.wcnt + 23'd1; // [RL11]
                if (st.wcnt == 23'(TEST_WAIT - 32'd1)) begin
                    next_st.test_done = 1'b1;
                    next_st.need_reset = 1'b1; // [RL13]
                    next_st.test_pend = 1'b0;
                    next_st.state = H_IDLE;
                end
            end
            default: begin
                next_st = HOST_RST;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            st <= HOST_RST;
        end else begin
            st <= next_st;
        end
    end

    assign LINK.ncs = st.ncs;
    assign LINK.sclk = st.sclk;
    assign LINK.mosi = st.mosi;
    assign LINK.chip_rst = st.chip_rst;
    assign CMD_READY = st.ready;
    assign RSP_VALID = st.rsp_valid;
    assign RSP_RDATA = st.rsp_data;
    assign SELFTEST_DONE = st.test_done;

endmodule : fssr_host

// ---- shared/fssr_defines.svh ----
// Constants for the frame statistics and self-test register bank.
// Assumes inclusion by bare name from shared/ on the include path.
`ifndef FSSR_DEFINES_SVH
`define FSSR_DEFINES_SVH

// Register offsets on the serial port
`define FSSR_ADDR_PIX_TOTAL 7'h0a
`define FSSR_ADDR_DARKEST 7'h0b
`define FSSR_ADDR_RESULT0 7'h0c
`define FSSR_ADDR_RESULT1 7'h0d
`define FSSR_ADDR_RESULT2 7'h0e
`define FSSR_ADDR_RESULT3 7'h0f
`define FSSR_ADDR_DIAG 7'h10
`define FSSR_ADDR_RES_CFG 7'h12

// Reset values
`define FSSR_RST_PIX_TOTAL 8'h80
`define FSSR_RST_DARKEST 8'h00
`define FSSR_RST_RESULT 8'h00
`define FSSR_RST_RES_CFG 8'h28

// Self-test result bytes
`define FSSR_RESULT0_VAL 8'hf4
`define FSSR_RESULT1_VAL 8'h54
`define FSSR_RESULT2_VAL 8'h6d
`define FSSR_RESULT3_VAL 8'heb

// Field positions
`define FSSR_DIAG_RUN_POS 0
`define FSSR_CPI_HI 6
`define FSSR_CPI_LO 5
`define FSSR_CMD_WRITE_POS 7

// Limits of the frame statistics
`define FSSR_PIX_MAX 8'hfe
`define FSSR_TOTAL_MAX 8'ha7

// Timing
`define FSSR_CLK_HZ 64'd20000000
`define FSSR_TEST_MS 64'd250
`define FSSR_TEST_CYC_DEF (`FSSR_TEST_MS * `FSSR_CLK_HZ / 64'd1000)
`define FSSR_TEST_MARGIN 32'd64
`define FSSR_SCLK_HALF 5'd16
`define FSSR_CHIP_RST_CYC 5'd8

`endif

// ---- shared/fssr_link_if.sv ----
// Four-wire serial link plus chip reset between host and sensor.
// Assumes both ends run on the same nominal clock but sample pins asynchronously.
`timescale 1ns/1ns
interface fssr_link_if;
    logic ncs;
    logic sclk;
    logic mosi;
    logic chip_rst;
    logic miso;
    logic miso_oe;
    logic miso_line;

    // Weak pull-up when the sensor releases its data output
    assign miso_line = miso_oe ? miso : 1'b1;

    modport device (
        input ncs,
        input sclk,
        input mosi,
        input chip_rst,
        output miso,
        output miso_oe
    );

    modport host (
        output ncs,
        output sclk,
        output mosi,
        output chip_rst,
        input miso_line
    );
endinterface : fssr_link_if

// ---- shared/fssr_pkg.sv ----
// Types for the frame statistics and self-test register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package fssr_pkg;

    typedef enum logic {
        D_RUN = 1'b0,
        D_TEST = 1'b1
    } fssr_mode_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_RESET = 3'b001,
        H_LEAD = 3'b010,
        H_BITS = 3'b011,
        H_TAIL = 3'b100,
        H_TEST = 3'b101
    } fssr_hstate_t;

    typedef struct packed {
        logic [3:0][2:0] syn;
        logic [3:0] pin;
        fssr_mode_t mode;
        logic [22:0] tcnt;
        logic [4:0] bits;
        logic [7:0] shin;
        logic [7:0] cmd;
        logic [7:0] tx;
        logic miso_oe;
        logic [17:0] acc;
        logic [7:0] minv;
        logic [7:0] total;
        logic [7:0] darkest;
        logic [7:0] res;
        logic [3:0][7:0] result;
        logic [11:0] scaled;
    } fssr_dev_st_t;

    typedef struct packed {
        fssr_hstate_t state;
        logic [4:0] tmr;
        logic [5:0] hcnt;
        logic [15:0] sh;
        logic [7:0] rx;
        logic ncs;
        logic sclk;
        logic mosi;
        logic chip_rst;
        logic [2:0] ms;
        logic miso_f;
        logic ready;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic test_pend;
        logic need_reset;
        logic test_done;
        logic [4:0] shadow;
        logic [22:0] wcnt;
    } fssr_host_st_t;

endpackage : fssr_pkg

// ---- test/frame_stats_selftest_regs_bench.sv ----
// Bench of the host and device ends joined by the serial link.
// Assumes short self-test counts so the run stays brief.
`timescale 1ns/1ns
`include "fssr_defines.svh"
module frame_stats_selftest_regs_bench;
    import fssr_pkg::*;
    localparam int unsigned TC = 100;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [6:0] cmd_addr = 7'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic cmd_ready, rsp_valid, selftest_done, selftest_busy;
    logic [7:0] rsp_rdata;
    logic pix_valid = 1'b0;
    logic [7:0] pix_data = 8'h00;
    logic frame_end = 1'b0;
    logic mot_valid = 1'b0;
    logic [7:0] mot_step = 8'h00;
    logic [11:0] mot_scaled;
    logic [1:0] cpi_select;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    int busy_n = 0;

    fssr_link_if link ();
    fssr_host #(.TEST_WAIT(TC + 20)) i_fssr_host (.CLK_SYS(clk_sys), .SRST(srst), .LINK(link),
        .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr),
        .CMD_WDATA(cmd_wdata), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid),
        .RSP_RDATA(rsp_rdata), .SELFTEST_DONE(selftest_done));
    fssr_device #(.TEST_CYCLES(TC)) i_fssr_device (.CLK_SYS(clk_sys), .SRST(srst),
        .LINK(link), .PIX_VALID(pix_valid), .PIX_DATA(pix_data), .FRAME_END(frame_end),
        .MOT_VALID(mot_valid), .MOT_STEP(mot_step), .MOT_SCALED(mot_scaled),
        .CPI_SELECT(cpi_select), .SELFTEST_BUSY(selftest_busy));
    fssr_link_props i_fssr_link_props (.CLK_SYS(clk_sys), .SRST(srst), .ncs(link.ncs),
        .sclk(link.sclk), .mosi(link.mosi), .chip_rst(link.chip_rst), .miso(link.miso),
        .miso_oe(link.miso_oe));

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    always @(posedge clk_sys) begin
        cycles++;
        if (selftest_busy === 1'b1) begin
            busy_n++;
        end
        if (cycles == 60000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One host command, held until taken, then wait for its response
    task automatic cmd(input logic w, input logic [6:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        n = 0;
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr <= a;
        cmd_wdata <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (cmd_ready !== 1'b1 && n < 5000);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rsp_valid !== 1'b1 && n < 5000);
        q = rsp_rdata;
        if (n >= 5000) begin
            n_fail++;
        end
    endtask : cmd

    task automatic t_reset_values();
        logic [6:0] addrs [9];
        logic [7:0] exps [9];
        logic [7:0] q;
        addrs = '{7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h11, 7'h12};
        exps = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h28};
        for (int i = 0; i < 9; i++) begin
            cmd(1'b0, addrs[i], 8'h00, q);
            chk(16'(q), 16'(exps[i]));
        end
        chk(16'(cpi_select), 16'h0001);
    endtask : t_reset_values

    task automatic frame(input int cnt, input logic [7:0] first, input logic [7:0] v);
        for (int i = 0; i < cnt; i++) begin
            pix_valid <= 1'b1;
            pix_data <= (i == 0) ? first : v;
            frame_end <= (i == cnt - 1);
            @(posedge clk_sys);
        end
        pix_valid <= 1'b0;
        frame_end <= 1'b0;
        @(posedge clk_sys);
    endtask : frame

    task automatic t_frames();
        logic [7:0] q;
        frame(676, 8'h07, 8'hc8);
        cmd(1'b1, 7'h0a, 8'h00, q);
        cmd(1'b0, 7'h0a, 8'h00, q);
        chk(16'(q), 16'd131);
        chk(16'(int'(q) * 1024 / 676), 16'd198);
        cmd(1'b0, 7'h0b, 8'h00, q);
        chk(16'(q), 16'd7);
        frame(1000, 8'hff, 8'hff);
        cmd(1'b0, 7'h0a, 8'h00, q);
        chk(16'(q), 16'd167);
        cmd(1'b0, 7'h0b, 8'h00, q);
        chk(16'(q), 16'd254);
    endtask : t_frames

    task automatic t_resolution();
        logic [7:0] q;
        logic [7:0] steps [2];
        steps = '{8'hfd, 8'h05};
        for (int c = 0; c < 4; c++) begin
            cmd(1'b1, 7'h12, {1'b1, 2'(c), 5'h1f}, q);
            cmd(1'b0, 7'h12, 8'h00, q);
            chk(16'(q), 16'({1'b0, 2'(c), 5'h08}));
            chk(16'(cpi_select), 16'(c));
            for (int s = 0; s < 2; s++) begin
                mot_valid <= 1'b1;
                mot_step <= steps[s];
                @(posedge clk_sys);
                mot_valid <= 1'b0;
                @(posedge clk_sys);
                @(posedge clk_sys);
                chk(16'(mot_scaled), 16'(12'({{4{steps[s][7]}}, steps[s]} * 12'(c + 1))));
            end
        end
    endtask : t_resolution

    task automatic t_selftest();
        logic [7:0] q;
        logic [7:0] res [4];
        int n;
        res = '{8'hf4, 8'h54, 8'h6d, 8'heb};
        cmd(1'b1, 7'h10, 8'h00, q);
        repeat (20) @(posedge clk_sys);
        chk(16'(busy_n), 16'h0000);
        cmd(1'b1, 7'h10, 8'h01, q);
        n = 0;
        while (selftest_done !== 1'b1 && n < 1000) begin
            @(posedge clk_sys);
            n++;
        end
        chk(16'(selftest_done), 16'h0001);
        chk(16'(busy_n >= TC && busy_n <= TC + 1), 16'h0001);
        chk(16'(selftest_busy), 16'h0000);
        for (int i = 0; i < 4; i++) begin
            cmd(1'b0, 7'(8'h0c + i), 8'h00, q);
            chk(16'(q), 16'(res[i]));
        end
        cmd(1'b0, 7'h0a, 8'h00, q);
        chk(16'(q), 16'h0080);
        cmd(1'b0, 7'h12, 8'h00, q);
        chk(16'(q), 16'h0028);
    endtask : t_selftest

    initial begin
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        t_reset_values();
        t_frames();
        t_resolution();
        t_selftest();
        finish_test();
    end
endmodule : frame_stats_selftest_regs_bench

// ---- test/fssr_link_props.sv ----
// Checker of the serial link and chip reset between the host and device ends.
// Assumes the bench instantiates it beside the link interface, on CLK_SYS and SRST.
`timescale 1ns/1ns
module fssr_link_props (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic ncs,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic chip_rst,
    input wire logic miso,
    input wire logic miso_oe
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SRST);

    sclk_in_frame_a: assert property (sclk |-> !ncs)
        else $error("serial clock high outside a frame");
    mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("host data changed while serial clock high");
    sclk_high_len_a: assert property ($rose(sclk) |-> sclk [*8])
        else $error("serial clock high phase too short");
    sclk_low_len_a: assert property ($fell(sclk) |-> !sclk [*8])
        else $error("serial clock low phase too short");
    frame_lead_a: assert property ($fell(ncs) |-> !sclk [*8])
        else $error("serial clock rose too soon after select");
    frame_gap_a: assert property ($rose(ncs) |-> ncs [*5])
        else $error("select high gap between frames too short");
    miso_release_a: assert property (ncs [*8] |-> !miso_oe)
        else $error("device drives data while not selected");
    chip_rst_len_a: assert property ($rose(chip_rst) |-> chip_rst [*8] ##[0:3] !chip_rst)
        else $error("chip reset pulse length wrong");
    chip_rst_idle_a: assert property (chip_rst |-> ncs && !sclk)
        else $error("serial traffic during chip reset");
    miso_steady_a: assert property (sclk [*8] |-> $stable(miso))
        else $error("device data changed late in serial clock high phase");
endmodule : fssr_link_props
